// ==== logic/sei_pkg.sv ====
package sei_pkg;

    // Serial clock edges that make up one byte (two per bit).
    localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
    // Edge that captures bit 1, in the middle of serial clock cycle 7.
    localparam logic [4:0] BIT1_EDGE_PH0  = 5'h0D;
    localparam logic [4:0] BIT1_EDGE_PH1  = 5'h0E;
    localparam logic [4:0] EDGE_CNT_RST   = 5'h00;
    localparam logic [4:0] EDGE_CNT_FIRST = 5'h01;

    // Reset values of the flags and control bits.
    localparam logic       TX_EMPTY_RST   = 1'b1;
    localparam logic       FLAG_RST       = 1'b0;
    localparam logic       CTRL_RST       = 1'b0;
    localparam logic [7:0] BYTE_RST       = 8'h00;

    // Synchroniser depth and the pin group that passes through it.
    localparam int         SYNC_STAGES    = 2;
    localparam int         PIN_SS         = 0;
    localparam int         PIN_SCLK       = 1;
    localparam int         PIN_COUNT      = 2;

endpackage : sei_pkg

// ==== logic/sei_sync.sv ====
`timescale 1ns/1ps
module sei_sync #(
    parameter int         WIDTH     = 1,
    parameter logic [0:0] RESET_VAL = 1'b0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Asynchronous inputs and their synchronised copy
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1;

    // The first stage feeds the second stage only, to contain metastability.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= {WIDTH{RESET_VAL}};
            q      <= {WIDTH{RESET_VAL}};
        end else begin
            stage1 <= d;
            q      <= stage1;
        end
    end

endmodule : sei_sync

// ==== logic/sei_core.sv ====
// Function
// - Overflow sets when receive buffer is still full at the bit 1 capture edge.
// - While overflow is set, new bytes are dropped and receive-full stays untouched.
// - Overflow clears after a status read followed by a data read.
// - Error enable lets overflow and mode fault raise the shared receive/error request.
// - Master drives clock and master-out; slave drives master-in instead.
// - Mode fault sets only with fault detect enabled; disabling never clears it.
// - Master with fault detect flags a fault whenever slave select is low.
// - Master fault clears port enable, sets transmit-empty, clears state, frees pins.
// - Slave with fault detect flags a fault when select rises mid-transfer.
// - Phase 0 starts on select fall; phase 1 on first clock edge.
// - Phase 0 select pulse without clocks faults; phase 1 does not.
// - A mode fault leaves master select unchanged.
// - A slave fault keeps port enable; the select rise behind it clears the transfer state.
// - Mode fault clears after flagged status read then control write, unless still faulting.
// - Transmit request needs empty, enable, port enabled and no DMA.
// - Receive request needs full, enable and no DMA, port enable irrelevant.
// - Receive-full clears after a flagged status read then a data read.
// - Only a transmit data write clears transmit-empty.
// - Receive-full sets whenever a completed byte enters the receive buffer.
// - Transmit-empty sets whenever the transmit buffer loads the shift register.
// - Deselected slave floats master-in/slave-out and ignores clock edges.
// - Receive-full, overflow and mode fault reset only on system reset.
`timescale 1ns/1ps
module sei_core (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Processor access strobes, one cycle each
    input  wire logic       status_read,
    input  wire logic       data_read,
    input  wire logic       data_write,
    input  wire logic [7:0] data_wdata,
    input  wire logic       control_write,
    input  wire logic       status_control_write,
    // Control write data
    input  wire logic       wr_port_enable,
    input  wire logic       wr_master_select,
    input  wire logic       wr_clock_phase,
    input  wire logic       wr_clock_polarity,
    input  wire logic       wr_tx_irq_enable,
    input  wire logic       wr_rx_irq_enable,
    input  wire logic       wr_dma_select,
    // Status/control write data
    input  wire logic       wr_error_irq_enable,
    input  wire logic       wr_fault_detect_enable,
    // Shift engine events, same clock
    input  wire logic       eng_bit1_capture,
    input  wire logic       eng_byte_done,
    input  wire logic [7:0] eng_rx_byte,
    input  wire logic       eng_tx_load,
    input  wire logic       eng_sclk_out,
    input  wire logic       eng_mosi_out,
    input  wire logic       eng_miso_out,
    // Shared port direction bits: 0 clock, 1 master-out, 2 master-in
    input  wire logic [2:0] gpio_dir,
    // Pins
    input  wire logic       slave_select_n_pin,
    input  wire logic       serial_clock_pin_in,
    output logic            serial_clock_pin_out,
    output logic            serial_clock_pin_oe,
    output logic            mosi_out,
    output logic            mosi_oe,
    output logic            miso_out,
    output logic            miso_oe,
    // Status
    output logic            port_enable,
    output logic            master_select,
    output logic            clock_phase,
    output logic            error_irq_enable,
    output logic            fault_detect_enable,
    output logic            transmit_empty_flag,
    output logic            receive_full_flag,
    output logic            overflow_flag,
    output logic            mode_fault_flag,
    output logic [7:0]      rx_data,
    output logic [7:0]      tx_data,
    output logic            slave_in_progress,
    output logic            state_clear,
    // Interrupt requests
    output logic            tx_irq,
    output logic            rx_err_irq
);

    logic                                 rst_sync_n;
    logic [sei_pkg::PIN_COUNT-1:0]        pin_sync;
    logic                                 clock_polarity;
    logic                                 tx_irq_enable;
    logic                                 rx_irq_enable;
    logic                                 dma_select;
    logic                                 ss_d;
    logic                                 sclk_d;
    logic [4:0]                           edge_cnt;
    logic                                 rf_armed;
    logic                                 ovf_armed;
    logic                                 mf_armed;
    logic                                 eng_sclk_q;
    logic                                 eng_mosi_q;
    logic                                 eng_miso_q;

    sei_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (1'b1),
        .q     (rst_sync_n)
    );

    sei_sync #(.WIDTH(sei_pkg::PIN_COUNT), .RESET_VAL(1'b1)) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_sync_n),
        .d     ({serial_clock_pin_in, slave_select_n_pin}),
        .q     (pin_sync)
    );

    // Decoding.
    wire ss_s         = pin_sync[sei_pkg::PIN_SS];
    wire sclk_s       = pin_sync[sei_pkg::PIN_SCLK];
    wire is_master    = port_enable & master_select;
    wire is_slave     = port_enable & ~master_select;
    wire ss_fall      = ~ss_s & ss_d;
    wire ss_rise      = ss_s & ~ss_d;
    wire sclk_edge    = (sclk_s ^ sclk_d) & ~ss_s;
    wire leave_idle   = sclk_edge & (sclk_s != clock_polarity);
    wire ph1_start    = is_slave & clock_phase & ~slave_in_progress & leave_idle;
    wire ph0_start    = is_slave & ~clock_phase & ss_fall;
    wire count_edge   = is_slave & slave_in_progress & sclk_edge;
    wire [4:0] cnt_inc = 5'(edge_cnt + sei_pkg::EDGE_CNT_FIRST);
    wire slave_done   = count_edge & (cnt_inc == sei_pkg::EDGES_PER_BYTE);
    wire [4:0] bit1_edge = clock_phase ? sei_pkg::BIT1_EDGE_PH1 : sei_pkg::BIT1_EDGE_PH0;
    wire slave_bit1   = count_edge & (cnt_inc == bit1_edge);
    wire master_fault = is_master & fault_detect_enable & ~ss_s;
    wire slave_fault  = is_slave & fault_detect_enable & ss_rise & slave_in_progress;
    wire fault_now    = master_fault | slave_fault;
    wire bit1_evt     = slave_bit1 | (is_master & eng_bit1_capture);
    wire byte_evt     = slave_done | (is_master & eng_byte_done);
    wire set_ovf      = bit1_evt & receive_full_flag;
    wire load_rx      = byte_evt & ~overflow_flag & ~set_ovf;
    wire clr_rf       = data_read & rf_armed;
    wire clr_ovf      = data_read & ovf_armed;
    wire clr_mf       = control_write & mf_armed & ~fault_now;
    wire set_te       = eng_tx_load | master_fault | ~port_enable;

    assign state_clear = master_fault | ~port_enable;

    // Next values of the slave transfer tracker.
    logic       next_in_progress;
    logic [4:0] next_edge_cnt;
    always_comb begin
        next_in_progress = slave_in_progress;
        next_edge_cnt    = edge_cnt;
        if (!is_slave || ss_s) begin
            next_in_progress = 1'b0;
            next_edge_cnt    = sei_pkg::EDGE_CNT_RST;
        end else if (ph0_start) begin
            next_in_progress = 1'b1;
            next_edge_cnt    = sei_pkg::EDGE_CNT_RST;
        end else if (ph1_start) begin
            next_in_progress = 1'b1;
            next_edge_cnt    = sei_pkg::EDGE_CNT_FIRST;
        end else if (slave_done) begin
            next_in_progress = 1'b0;
            next_edge_cnt    = sei_pkg::EDGE_CNT_RST;
        end else if (count_edge) begin
            next_edge_cnt    = cnt_inc;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ss_d              <= 1'b1;
            sclk_d            <= 1'b1;
            slave_in_progress <= 1'b0;
            edge_cnt          <= sei_pkg::EDGE_CNT_RST;
        end else begin
            ss_d              <= ss_s;
            sclk_d            <= sclk_s;
            slave_in_progress <= next_in_progress;
            edge_cnt          <= next_edge_cnt;
        end
    end

    // Control bits survive a disabled port so software need not rewrite them.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            port_enable    <= sei_pkg::CTRL_RST;
            master_select  <= sei_pkg::CTRL_RST;
            clock_phase    <= sei_pkg::CTRL_RST;
            clock_polarity <= sei_pkg::CTRL_RST;
            tx_irq_enable  <= sei_pkg::CTRL_RST;
            rx_irq_enable  <= sei_pkg::CTRL_RST;
            dma_select     <= sei_pkg::CTRL_RST;
        end else begin
            if (control_write) begin
                master_select  <= wr_master_select;
                clock_phase    <= wr_clock_phase;
                clock_polarity <= wr_clock_polarity;
                tx_irq_enable  <= wr_tx_irq_enable;
                rx_irq_enable  <= wr_rx_irq_enable;
                dma_select     <= wr_dma_select;
            end
            // The fault must beat a simultaneous enabling write.
            if (master_fault)
                port_enable <= 1'b0;
            else if (control_write)
                port_enable <= wr_port_enable;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            error_irq_enable    <= sei_pkg::CTRL_RST;
            fault_detect_enable <= sei_pkg::CTRL_RST;
        end else if (status_control_write) begin
            error_irq_enable    <= wr_error_irq_enable;
            fault_detect_enable <= wr_fault_detect_enable;
        end
    end

    // Flags; a set in the same cycle as a clear always wins.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            transmit_empty_flag <= sei_pkg::TX_EMPTY_RST;
            receive_full_flag   <= sei_pkg::FLAG_RST;
            overflow_flag       <= sei_pkg::FLAG_RST;
            mode_fault_flag     <= sei_pkg::FLAG_RST;
        end else begin
            transmit_empty_flag <= set_te | (transmit_empty_flag & ~data_write);
            receive_full_flag   <= load_rx | (receive_full_flag & ~clr_rf);
            overflow_flag       <= set_ovf | (overflow_flag & ~clr_ovf);
            mode_fault_flag     <= fault_now | (mode_fault_flag & ~clr_mf);
        end
    end

    // A status read arms the clear only for flags that were set when it was read.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rf_armed  <= 1'b0;
            ovf_armed <= 1'b0;
            mf_armed  <= 1'b0;
        end else begin
            rf_armed  <= status_read ? receive_full_flag : (rf_armed & ~data_read);
            ovf_armed <= status_read ? overflow_flag : (ovf_armed & ~data_read);
            mf_armed  <= status_read ? mode_fault_flag : (mf_armed & ~control_write);
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            rx_data <= sei_pkg::BYTE_RST;
            tx_data <= sei_pkg::BYTE_RST;
        end else begin
            if (load_rx)
                rx_data <= eng_rx_byte;
            if (data_write)
                tx_data <= data_wdata;
        end
    end

    // Pin data is registered; directions follow the mode at once.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            eng_sclk_q <= 1'b0;
            eng_mosi_q <= 1'b0;
            eng_miso_q <= 1'b0;
        end else begin
            eng_sclk_q <= eng_sclk_out;
            eng_mosi_q <= eng_mosi_out;
            eng_miso_q <= eng_miso_out;
        end
    end

    assign serial_clock_pin_out = eng_sclk_q;
    assign mosi_out             = eng_mosi_q;
    assign miso_out             = eng_miso_q;
    assign serial_clock_pin_oe  = port_enable ? master_select : gpio_dir[0];
    assign mosi_oe              = port_enable ? master_select : gpio_dir[1];
    assign miso_oe              = port_enable ? (~master_select & ~ss_s) : gpio_dir[2];

    assign tx_irq     = transmit_empty_flag & tx_irq_enable & port_enable & ~dma_select;
    assign rx_err_irq = (receive_full_flag & rx_irq_enable & ~dma_select)
                      | (error_irq_enable & (overflow_flag | mode_fault_flag));

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    a_ovf_on_bit1: assert property (bit1_evt && receive_full_flag |=> overflow_flag)
        else $error("overflow not set at bit 1 capture");
    a_drop_on_ovf: assert property (overflow_flag && byte_evt |=> $stable(rx_data))
        else $error("byte accepted during overflow");
    a_ovf_clear: assert property ($fell(overflow_flag) |-> $past(data_read) && $past(ovf_armed))
        else $error("overflow cleared without sequence");
    a_err_request: assert property (error_irq_enable && (overflow_flag || mode_fault_flag) |-> rx_err_irq)
        else $error("error request missing");
    a_master_dirs: assert property (port_enable && master_select |-> serial_clock_pin_oe && mosi_oe && !miso_oe)
        else $error("master pin directions wrong");
    a_mf_needs_fde: assert property ($rose(mode_fault_flag) |-> $past(fault_detect_enable))
        else $error("mode fault without detect enable");
    a_master_fault: assert property (master_fault |=> mode_fault_flag && !port_enable && transmit_empty_flag)
        else $error("master fault effects missing");
    a_slave_fault: assert property (slave_fault |=> mode_fault_flag && $stable(port_enable))
        else $error("slave fault handling wrong");
    a_ms_kept: assert property (fault_now && !control_write |=> $stable(master_select))
        else $error("master select changed by fault");
    a_mf_held: assert property (mode_fault_flag && fault_now |=> mode_fault_flag)
        else $error("mode fault cleared while faulting");
    a_tx_request: assert property (tx_irq |-> transmit_empty_flag && port_enable && !dma_select)
        else $error("transmit request without cause");
    a_rf_clear: assert property ($fell(receive_full_flag) |-> $past(data_read) && $past(rf_armed))
        else $error("receive-full cleared without sequence");
    a_te_clear: assert property ($fell(transmit_empty_flag) |-> $past(data_write))
        else $error("transmit-empty cleared without write");
    a_rf_set: assert property (load_rx |=> receive_full_flag && rx_data == $past(eng_rx_byte))
        else $error("receive byte not stored");
    a_miso_float: assert property (is_slave && ss_s |-> !miso_oe && !count_edge)
        else $error("deselected slave active");

    c_overflow: cover property (set_ovf ##1 overflow_flag);
    c_master_fault: cover property (master_fault);
    c_slave_ph0_pulse: cover property (ph0_start ##[1:40] slave_fault);
    c_slave_byte: cover property (slave_done ##1 receive_full_flag);

endmodule : sei_core

// ==== tb/sei_remote.sv ====
`timescale 1ns/1ps
module sei_remote (
    // Bench clock, used only to pace the link
    input  wire logic clk,
    // Link pins towards the block
    output logic      slave_select_n,
    output logic      serial_clock
);
    // The link clock stands at its idle level between frames.
    initial begin
        slave_select_n = 1'b1;
        serial_clock   = 1'b0;
    end
    task automatic select(input logic lvl);
        @(posedge clk);
        slave_select_n <= lvl;
    endtask : select
    // Each edge is half of a 160 ns link period, so ten bench clocks.
    task automatic edges(input int n);
        repeat (n) begin
            repeat (10) @(posedge clk);
            serial_clock <= ~serial_clock;
        end
    endtask : edges
endmodule : sei_remote

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  stb = 8'h00;
    logic [6:0]  cfg = 7'h00;
    logic [1:0]  scw = 2'h0;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  rxb = 8'h00;
    logic [2:0]  dir = 3'h5;
    logic [2:0]  eng3 = 3'h0;
    logic [2:0]  prev3 = 3'h0;
    logic [31:0] seed = 32'h0000_005C;
    logic [7:0]  b1;
    int          err_total = 0;
    int          checks = 0;
    int          cyc = 0;
    logic        ss_n;
    logic        sclk;
    logic        sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
    logic        pe, ms, ph, erie, fde, te, rf, ovf, mf, sip, sclr, txi, rxi;
    logic [7:0]  rxd, txd;

    always #4 clk = ~clk;

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs

    // Random engine pin data keeps the registered pin path busy.
    always @(posedge clk) begin
        seed  <= xs(seed);
        eng3  <= seed[2:0];
        prev3 <= eng3;
        cyc   <= cyc + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            test_done();
        end
    end

    sei_remote i_remote (.clk(clk), .slave_select_n(ss_n), .serial_clock(sclk));

    sei_core i_dut (
        .clk(clk), .rst_n(rst_n),
        .status_read(stb[0]), .data_read(stb[1]), .data_write(stb[2]), .data_wdata(wdata),
        .control_write(stb[3]), .status_control_write(stb[4]),
        .wr_port_enable(cfg[6]), .wr_master_select(cfg[5]), .wr_clock_phase(cfg[4]),
        .wr_clock_polarity(cfg[3]), .wr_tx_irq_enable(cfg[2]), .wr_rx_irq_enable(cfg[1]),
        .wr_dma_select(cfg[0]), .wr_error_irq_enable(scw[1]), .wr_fault_detect_enable(scw[0]),
        .eng_bit1_capture(stb[5]), .eng_byte_done(stb[6]), .eng_rx_byte(rxb), .eng_tx_load(stb[7]),
        .eng_sclk_out(eng3[0]), .eng_mosi_out(eng3[1]), .eng_miso_out(eng3[2]), .gpio_dir(dir),
        .slave_select_n_pin(ss_n), .serial_clock_pin_in(sclk),
        .serial_clock_pin_out(sclk_o), .serial_clock_pin_oe(sclk_oe), .mosi_out(mosi_o),
        .mosi_oe(mosi_oe), .miso_out(miso_o), .miso_oe(miso_oe),
        .port_enable(pe), .master_select(ms), .clock_phase(ph), .error_irq_enable(erie),
        .fault_detect_enable(fde), .transmit_empty_flag(te), .receive_full_flag(rf),
        .overflow_flag(ovf), .mode_fault_flag(mf), .rx_data(rxd), .tx_data(txd),
        .slave_in_progress(sip), .state_clear(sclr), .tx_irq(txi), .rx_err_irq(rxi)
    );

    task automatic test_done();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        stb <= m;
        @(posedge clk);
        stb <= 8'h00;
        // Results are looked at half a cycle later, once the launching edge has settled.
        @(negedge clk);
    endtask : pulse

    // Control bits {enable, master, phase, polarity, tx, rx, dma}.
    task automatic ctl(input logic [6:0] v);
        @(posedge clk);
        cfg <= v;
        pulse(8'h08);
    endtask : ctl

    task automatic stc(input logic [1:0] v);
        @(posedge clk);
        scw <= v;
        pulse(8'h10);
    endtask : stc

    task automatic wait_link();
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask : wait_link

    function automatic logic [7:0] oes(input logic m);
        return m ? 8'h03 : 8'h04;
    endfunction : oes

    // Requests as the rules define them, from flags {te, rf, ovf, mf} and the written enables.
    function automatic logic [1:0] irq_exp(input logic [6:0] v, input logic [1:0] s, input logic [3:0] f);
        return {f[3] & v[2] & v[6] & ~v[0], (f[2] & v[1] & ~v[0]) | (s[1] & (f[1] | f[0]))};
    endfunction : irq_exp

    // Random register and engine traffic with the link idle; a small flag model predicts each result.
    task automatic rnd_phase();
        logic [31:0] r;
        logic [6:0]  v;
        logic [1:0]  s;
        logic [7:0]  m;
        logic [7:0]  e;
        logic [7:0]  rx_m;
        logic [7:0]  tx_m;
        logic        te_m, rf_m, ovf_m, mf_m, pe_m, ra, oa, ma, set_o, ld, clr_r, clr_o;
        te_m  = 1'b1;
        rf_m  = 1'b1;
        ovf_m = 1'b0;
        mf_m  = 1'b1;
        pe_m  = 1'b0;
        ra    = 1'b0;
        oa    = 1'b0;
        ma    = 1'b0;
        rx_m  = b1;
        tx_m  = 8'h5A;
        for (int i = 0; i < 40; i++) begin
            r = seed;
            v = r[6:0];
            s = r[8:7];
            m = r[16:9] & 8'hE7;
            ctl(v);
            mf_m = mf_m & ~ma;
            ma   = 1'b0;
            te_m = te_m | ~pe_m;
            pe_m = v[6];
            stc(s);
            te_m  = te_m | ~pe_m;
            rxb   <= r[31:24];
            wdata <= r[24:17];
            pulse(m);
            set_o = pe_m & v[5] & m[5] & rf_m;
            ld    = pe_m & v[5] & m[6] & ~ovf_m & ~set_o;
            clr_r = m[1] & ra;
            clr_o = m[1] & oa;
            ra    = m[0] ? rf_m : (ra & ~m[1]);
            oa    = m[0] ? ovf_m : (oa & ~m[1]);
            ma    = m[0] ? mf_m : ma;
            rf_m  = ld | (rf_m & ~clr_r);
            ovf_m = set_o | (ovf_m & ~clr_o);
            te_m  = m[7] | ~pe_m | (te_m & ~m[2]);
            if (ld)
                rx_m = r[31:24];
            if (m[2])
                tx_m = r[24:17];
            e = {te_m, rf_m, ovf_m, mf_m, v[6:5], irq_exp(v, s, {te_m, rf_m, ovf_m, mf_m})};
            chk({te, rf, ovf, mf, pe, ms, txi, rxi}, e);
            chk({ph, erie, fde, 5'h0}, {v[4], s, 5'h0});
            chk(rxd, rx_m);
            chk(txd, tx_m);
        end
    endtask : rnd_phase

    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk);
        @(negedge clk);
        chk({te, rf, ovf, mf, pe, txi, rxi, sclr}, 8'h81);
        chk({5'h0, miso_oe, mosi_oe, sclk_oe}, {5'h0, dir});
        ctl(7'h66);
        chk({5'h0, miso_oe, mosi_oe, sclk_oe}, oes(1'b1));
        chk({7'h0, mosi_o}, {7'h0, prev3[1]});
        wdata <= seed[15:8];
        pulse(8'h04);
        chk({te, txi, txd}, {2'b00, wdata});
        pulse(8'h01);
        chk({7'h0, te}, 8'h00);
        pulse(8'h80);
        chk({6'h0, te, txi}, 8'h03);
        b1 = seed[7:0];
        rxb <= b1;
        pulse(8'h40);
        chk({rf, rxi, 6'h0}, 8'hC0);
        chk(rxd, b1);
        pulse(8'h02);
        chk({7'h0, rf}, 8'h01);
        pulse(8'h20);
        chk({7'h0, ovf}, 8'h01);
        rxb <= ~b1;
        pulse(8'h40);
        chk(rxd, b1);
        ctl(7'h64);
        chk({7'h0, rxi}, 8'h00);
        stc(2'b10);
        chk({7'h0, rxi}, 8'h01);
        pulse(8'h01);
        pulse(8'h02);
        chk({6'h0, rf, ovf}, 8'h00);
        ctl(7'h65);
        chk({7'h0, txi}, 8'h00);
        dir <= seed[10:8];
        stc(2'b11);
        ctl(7'h64);
        wdata <= 8'h5A;
        pulse(8'h04);
        i_remote.select(1'b0);
        wait_link();
        chk({mf, pe, te, ms, rxi, 3'h0}, 8'hB8);
        chk({5'h0, miso_oe, mosi_oe, sclk_oe}, {5'h0, dir});
        pulse(8'h01);
        ctl(7'h24);
        // With the port already off no fault condition remains, so the sequence clears the flag.
        chk({7'h0, mf}, 8'h00);
        i_remote.select(1'b1);
        wait_link();
        pulse(8'h01);
        ctl(7'h24);
        chk({7'h0, mf}, 8'h00);
        ctl(7'h40);
        i_remote.select(1'b0);
        wait_link();
        chk({5'h0, miso_oe, mosi_oe, sclk_oe}, oes(1'b0));
        chk({7'h0, sip}, 8'h01);
        i_remote.select(1'b1);
        wait_link();
        chk({mf, pe, 6'h0}, 8'hC0);
        chk({7'h0, miso_oe}, 8'h00);
        stc(2'b10);
        chk({7'h0, mf}, 8'h01);
        pulse(8'h01);
        ctl(7'h40);
        i_remote.select(1'b0);
        wait_link();
        i_remote.select(1'b1);
        wait_link();
        chk({7'h0, mf}, 8'h00);
        stc(2'b11);
        ctl(7'h50);
        i_remote.select(1'b0);
        wait_link();
        i_remote.select(1'b1);
        wait_link();
        chk({7'h0, mf}, 8'h00);
        b1 = seed[23:16];
        rxb <= b1;
        i_remote.select(1'b0);
        i_remote.edges(16);
        wait_link();
        chk({rf, mf, sip, 5'h0}, 8'h80);
        chk(rxd, b1);
        i_remote.edges(4);
        i_remote.select(1'b1);
        wait_link();
        chk({mf, pe, 6'h0}, 8'hC0);
        ctl(7'h00);
        chk({rf, mf, te, 5'h0}, 8'hE0);
        rnd_phase();
        test_done();
    end
endmodule : tb_top
